// File: rtl/pxr_readout.sv
// Purpose: digital side of a proximity sensor: serial slave, registers, thresholds, interrupt
// Assumes: front end delivers one raw sample per start pulse on its own clock fe_clk
// Notes: bus pins are oversampled on ref_clk; sda is open drain, int_n is driven both high and low
`timescale 1ns/100ps
module pxr_readout
	import pxr_pkg::*;
#(
	parameter int PERIOD_CYC = PERIOD_BASE_CYC,
	parameter logic [3:0] ID_VERSION = 4'h3, // Arbitrary value
	parameter logic [7:0] ID_LOW = 8'h5a // Arbitrary value
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic int_n,
	input wire logic fe_clk,
	input wire logic fe_valid,
	input wire logic fe_sun,
	input wire logic [11:0] fe_raw,
	output logic fe_start
);
	// ----------------------------------------------------------------
	// State and reset values
	// ----------------------------------------------------------------
	localparam pxr_state_t STATE_RST = '{scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1, sda_m: 1'b1,
		sda_s: 1'b1, sda_p: 1'b1, st: BS_IDLE, regs: REGS_RST, int_n: 1'b1, default: '0};
	localparam pxr_fe_state_t FE_RST = '0;

	pxr_state_t s, next_s;
	pxr_fe_state_t f, next_f;
	logic rise, fall, start_c, stop_c, newsmp, wr_en, rd_flags, ev_any;
	logic [15:0] wr_data, set_m, clr_m;
	logic [11:0] adj;
	logic [31:0] period;
	logic [7:0] nbyte;

	function automatic logic [15:0] rd_word(input logic [7:0] cmd, input pxr_regs_t r,
		input logic [15:0] result, input logic [15:0] flags);
		unique case (cmd)
			CMD_CONF1: return r.conf1;
			CMD_MCTL: return r.mctl;
			CMD_THDL: return r.thdl;
			CMD_THDH: return r.thdh;
			CMD_CANC: return r.canc;
			CMD_POR: return r.por;
			CMD_RESULT: return result;
			CMD_FLAGS: return flags;
			CMD_IDENT: return {2'b00, ID_ADDR_CODE, ID_VERSION, ID_LOW};
			default: return 16'h0000;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Reference clock domain
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		wr_en = 1'b0;
		wr_data = {s.sh, s.wlo};
		rd_flags = 1'b0;
		set_m = 16'h0000;
		nbyte = s.rdat[7:0];
		adj = 12'h000;
		// Two stages before any logic looks at the pins
		next_s.scl_m = scl;
		next_s.scl_s = s.scl_m;
		next_s.scl_p = s.scl_s;
		next_s.sda_m = sda_in;
		next_s.sda_s = s.sda_m;
		next_s.sda_p = s.sda_s;
		next_s.ack_m = f.ack_tgl;
		next_s.ack_s = s.ack_m;
		next_s.ack_p = s.ack_s;
		rise = s.scl_s & ~s.scl_p;
		fall = ~s.scl_s & s.scl_p;
		start_c = s.scl_s & s.scl_p & s.sda_p & ~s.sda_s;
		stop_c = s.scl_s & s.scl_p & ~s.sda_p & s.sda_s;
		newsmp = s.ack_s ^ s.ack_p;

		// Serial slave, 16-bit word per command, low byte first
		unique case (s.st)
			BS_IDLE: begin
				next_s.sda_oe = 1'b0;
			end
			BS_ADDR, BS_CMD, BS_WDATA: begin
				if (rise) begin
					next_s.sh = {s.sh[6:0], s.sda_s};
					next_s.bits = s.bits + 4'h1;
				end else if (fall && s.bits == 4'h8) begin
					next_s.bits = 4'h0;
					next_s.st = BS_ACK;
					next_s.sda_oe = 1'b1;
					if (s.st == BS_ADDR) begin
						next_s.phase = 2'h0;
						next_s.rw = s.sh[0];
						next_s.rdat = rd_word(s.cmd, s.regs, s.result, s.flags);
						rd_flags = s.sh[0] && s.cmd == CMD_FLAGS;
						if (s.sh[7:1] != DEV_ADDR) begin
							next_s.st = BS_IDLE;
							next_s.sda_oe = 1'b0;
							rd_flags = 1'b0;
						end
					end else if (s.st == BS_CMD) begin
						next_s.phase = 2'h1;
						next_s.cmd = s.sh;
					end else begin
						next_s.phase = 2'h2;
						next_s.bidx = ~s.bidx;
						if (!s.bidx) begin
							next_s.wlo = s.sh;
						end else begin
							wr_en = 1'b1;
						end
					end
				end
			end
			BS_ACK: begin
				if (fall) begin
					next_s.sda_oe = 1'b0;
					if (s.phase == 2'h0 && s.rw) begin
						next_s.st = BS_RDATA;
						next_s.bidx = 1'b0;
						next_s.obyte = s.rdat[7:0];
						next_s.sda_oe = ~s.rdat[7];
						next_s.bits = 4'h1;
					end else if (s.phase == 2'h0) begin
						next_s.st = BS_CMD;
					end else begin
						next_s.st = BS_WDATA;
						if (s.phase == 2'h1) begin
							next_s.bidx = 1'b0;
						end
					end
				end
			end
			BS_RDATA: begin
				if (fall && s.bits == 4'h8) begin
					next_s.sda_oe = 1'b0;
					next_s.st = BS_MACK;
				end else if (fall) begin
					next_s.sda_oe = ~s.obyte[3'd7 - s.bits[2:0]];
					next_s.bits = s.bits + 4'h1;
				end
			end
			BS_MACK: begin
				if (rise) begin
					next_s.mack = ~s.sda_s;
				end else if (fall && s.mack) begin
					nbyte = s.bidx ? s.rdat[7:0] : s.rdat[15:8];
					next_s.bidx = ~s.bidx;
					next_s.obyte = nbyte;
					next_s.sda_oe = ~nbyte[7];
					next_s.bits = 4'h1;
					next_s.st = BS_RDATA;
				end else if (fall) begin
					next_s.st = BS_IDLE;
				end
			end
		endcase
		if (start_c) begin
			next_s.st = BS_ADDR;
			next_s.bits = 4'h0;
			next_s.sda_oe = 1'b0;
		end else if (stop_c) begin
			next_s.st = BS_IDLE;
			next_s.sda_oe = 1'b0;
		end

		// Measurement scheduling: auto period or single shot
		period = PERIOD_CYC << s.regs.conf1[PERIOD_LSB +: 2];
		if (s.regs.mctl[AF_BIT] == 1'b0) begin
			next_s.regs.mctl[TRIG_BIT] = 1'b0;
			if (s.regs.conf1[SD_BIT]) begin
				next_s.tmr = 32'h0;
			end else if (s.tmr == 32'h0) begin
				next_s.tmr = period - 32'h1;
				if (!s.busy) begin
					next_s.req_tgl = ~s.req_tgl;
					next_s.busy = 1'b1;
				end
			end else begin
				next_s.tmr = s.tmr - 32'h1;
			end
		end else begin
			next_s.tmr = 32'h0;
			if (s.regs.mctl[TRIG_BIT] && !s.busy) begin
				next_s.req_tgl = ~s.req_tgl;
				next_s.busy = 1'b1;
				next_s.regs.mctl[TRIG_BIT] = 1'b0;
			end
		end

		// New sample: cancel, compare, persist
		if (newsmp) begin
			next_s.busy = 1'b0;
			next_s.sun_st = f.hold.sun;
			adj = f.hold.raw > s.regs.canc[11:0] ? f.hold.raw - s.regs.canc[11:0] : 12'h000;
			if (f.hold.sun) begin
				next_s.result = SUN_RESULT;
				set_m[FLAG_SUN] = ~s.sun_st;
			end else begin
				next_s.result = {4'h0, adj};
				if (adj > s.regs.thdh[11:0]) begin
					next_s.lo_cnt = 3'h0;
					next_s.hi_cnt = s.hi_cnt == 3'h4 ? s.hi_cnt : s.hi_cnt + 3'h1;
					if (!s.close && next_s.hi_cnt > {1'b0, s.regs.conf1[PERS_LSB +: 2]}) begin
						next_s.close = 1'b1;
						set_m[FLAG_CLOSE] = 1'b1;
					end
				end else if (adj < s.regs.thdl[11:0]) begin
					next_s.hi_cnt = 3'h0;
					next_s.lo_cnt = s.lo_cnt == 3'h4 ? s.lo_cnt : s.lo_cnt + 3'h1;
					if (s.close && next_s.lo_cnt > {1'b0, s.regs.conf1[PERS_LSB +: 2]}) begin
						next_s.close = 1'b0;
						set_m[FLAG_AWAY] = 1'b1;
					end
				end else begin
					// Between thresholds: detection state holds
					next_s.hi_cnt = 3'h0;
					next_s.lo_cnt = 3'h0;
				end
			end
		end
		if (!s.regs.conf1[INTM_LSB + 1]) begin
			set_m = 16'h0000;
		end
		ev_any = |set_m;
		// Set beats the clear of the same read
		clr_m = rd_flags ? s.flags : 16'h0000;
		next_s.flags = (s.flags & ~clr_m) | set_m;

		// Register writes after scheduling so a fresh trigger is kept
		if (wr_en) begin
			case (s.cmd)
				CMD_CONF1: next_s.regs.conf1 = wr_data;
				CMD_MCTL: next_s.regs.mctl = wr_data & MCTL_MASK;
				CMD_THDL: next_s.regs.thdl = wr_data & THD_MASK;
				CMD_THDH: next_s.regs.thdh = wr_data & THD_MASK;
				CMD_CANC: next_s.regs.canc = wr_data & THD_MASK;
				CMD_POR: next_s.regs.por = wr_data & POR_MASK;
				default: ;
			endcase
		end

		// Interrupt pin
		if (next_s.regs.conf1[INTM_LSB +: 2] == INTM_LOGIC) begin
			next_s.int_n = ~next_s.close;
		end else if (next_s.regs.conf1[INTM_LSB +: 2] == INTM_THRESH) begin
			next_s.int_n = ~(|next_s.flags);
		end else begin
			next_s.int_n = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= STATE_RST;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Front-end clock domain
	// ----------------------------------------------------------------
	// Hold stays put until the next request, which waits for busy to drop
	always_comb begin
		next_f = f;
		next_f.req_m = s.req_tgl;
		next_f.req_s = f.req_m;
		next_f.req_p = f.req_s;
		next_f.start = f.req_s ^ f.req_p;
		if (fe_valid) begin
			next_f.hold = '{sun: fe_sun, raw: fe_raw};
			next_f.ack_tgl = ~f.ack_tgl;
		end
	end

	always_ff @(posedge fe_clk or negedge reset_n) begin
		if (!reset_n) begin
			f <= FE_RST;
		end else begin
			f <= next_f;
		end
	end

	assign sda_out = s.sda_lo;
	assign sda_oe = s.sda_oe;
	assign int_n = s.int_n;
	assign fe_start = f.start;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	a_thdh_masked:
	assert property (s.regs.thdh[15:12] == 4'h0) else $error("high threshold upper bits set");
	a_canc_masked:
	assert property (s.regs.canc[15:12] == 4'h0) else $error("cancel level upper bits set");
	a_cancel_sub:
	assert property (newsmp && !f.hold.sun && f.hold.raw >= s.regs.canc[11:0]
		|=> s.result == {4'h0, $past(f.hold.raw) - $past(s.regs.canc[11:0])})
		else $error("result not cancel adjusted");
	a_sun_readout:
	assert property (s.sun_st |-> s.result == 16'h8000) else $error("sun readout wrong");
	a_result_upper:
	assert property (!s.result[15] |-> s.result[15:12] == 4'h0) else $error("result reserved bits set");
	a_int_on_flag:
	assert property ($rose(|s.flags) && s.regs.conf1[3:2] == INTM_THRESH |-> !s.int_n)
		else $error("int not low on flag");
	a_flag_read_clear:
	assert property (rd_flags && !ev_any |=> s.flags == 16'h0000 ##1 s.int_n || s.regs.conf1[3:2] == INTM_LOGIC)
		else $error("flags not cleared by read");
	a_persist_count:
	assert property ($rose(s.close) |-> s.hi_cnt > {1'b0, s.regs.conf1[5:4]})
		else $error("close before persistence");
	a_force_standby:
	assert property (s.regs.mctl[AF_BIT] && !s.regs.mctl[TRIG_BIT] |=> $stable(s.req_tgl))
		else $error("force mode measured without trigger");
	a_trig_clears:
	assert property (s.regs.mctl[AF_BIT] && s.regs.mctl[TRIG_BIT] && !s.busy && !wr_en
		|=> !s.regs.mctl[TRIG_BIT] && s.busy) else $error("trigger did not self clear");
	a_logic_output:
	assert property (s.regs.conf1[3:2] == INTM_LOGIC |-> s.int_n == !s.close)
		else $error("logic output mismatch");
	a_int_disabled:
	assert property (!s.regs.conf1[3] |-> s.int_n && s.flags == $past(s.flags) || rd_flags || $past(rd_flags))
		else $error("int active while disabled");
	a_start_pulse:
	assert property (@(posedge fe_clk) disable iff (!reset_n) f.start |=> !f.start)
		else $error("start longer than one cycle");

	c_close_event: cover property ($rose(s.flags[FLAG_CLOSE]));
	c_flag_read: cover property (rd_flags ##[1:400] $rose(s.int_n));
	c_sun_entry: cover property ($rose(s.sun_st));
	c_force_shot: cover property (s.regs.mctl[TRIG_BIT] ##1 s.busy ##[1:40] newsmp);
endmodule

// File: rtl/pxr_pkg.sv
// Purpose: shared constants and carriers for the proximity readout block
// Assumes: 40 MHz ref_clk, 16-bit registers reached by one-byte command codes
// Notes: all offsets, fields, resets and timing counts live here
package pxr_pkg;
	// ----------------------------------------------------------------
	// Bus address and command codes
	// ----------------------------------------------------------------
	localparam logic [6:0] DEV_ADDR = 7'h60;
	localparam logic [7:0] CMD_CONF1 = 8'h03;
	localparam logic [7:0] CMD_MCTL = 8'h04;
	localparam logic [7:0] CMD_THDL = 8'h05;
	localparam logic [7:0] CMD_THDH = 8'h06;
	localparam logic [7:0] CMD_CANC = 8'h07;
	localparam logic [7:0] CMD_POR = 8'h08;
	localparam logic [7:0] CMD_RESULT = 8'hf2;
	localparam logic [7:0] CMD_FLAGS = 8'hf3;
	localparam logic [7:0] CMD_IDENT = 8'hf4;
	// ----------------------------------------------------------------
	// Field positions, masks and reset values
	// ----------------------------------------------------------------
	localparam int PERIOD_LSB = 6;
	localparam int PERS_LSB = 4;
	localparam int INTM_LSB = 2;
	localparam int SD_BIT = 0;
	localparam int AF_BIT = 6;
	localparam int TRIG_BIT = 5;
	localparam int FLAG_AWAY = 8;
	localparam int FLAG_CLOSE = 9;
	localparam int FLAG_SUN = 13;
	localparam logic [1:0] INTM_THRESH = 2'h2;
	localparam logic [1:0] INTM_LOGIC = 2'h3;
	localparam logic [15:0] THD_MASK = 16'h0fff;
	localparam logic [15:0] MCTL_MASK = 16'hff60;
	localparam logic [15:0] POR_MASK = 16'h0001;
	localparam logic [15:0] SUN_RESULT = 16'h8000;
	localparam logic [1:0] ID_ADDR_CODE = 2'h0;
	localparam logic [15:0] CONF1_RST = 16'h0001;
	localparam logic [15:0] MCTL_RST = 16'h0000;
	localparam logic [15:0] THD_RST = 16'h0000;
	localparam logic [15:0] CANC_RST = 16'h0000;
	localparam logic [15:0] POR_RST = 16'h0000;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 40_000_000;
	localparam int PERIOD_BASE_US = 8000;
	localparam int PERIOD_BASE_CYC = PERIOD_BASE_US * (CLK_HZ / 1_000_000);
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [6:0] {
		BS_IDLE = 7'h01,
		BS_ADDR = 7'h02,
		BS_CMD = 7'h04,
		BS_WDATA = 7'h08,
		BS_ACK = 7'h10,
		BS_RDATA = 7'h20,
		BS_MACK = 7'h40
	} pxr_bus_state_t;
	typedef struct packed {
		logic [15:0] conf1;
		logic [15:0] mctl;
		logic [15:0] thdl;
		logic [15:0] thdh;
		logic [15:0] canc;
		logic [15:0] por;
	} pxr_regs_t;
	typedef struct packed {
		logic sun;
		logic [11:0] raw;
	} pxr_sample_t;
	typedef struct packed {
		logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
		pxr_bus_state_t st;
		logic [3:0] bits;
		logic [7:0] sh, cmd, wlo, obyte;
		logic [1:0] phase;
		logic rw, bidx, mack, sda_oe, sda_lo;
		logic [15:0] rdat;
		pxr_regs_t regs;
		logic [15:0] result, flags;
		logic close, sun_st;
		logic [2:0] hi_cnt, lo_cnt;
		logic [31:0] tmr;
		logic req_tgl, busy, ack_m, ack_s, ack_p, int_n;
	} pxr_state_t;
	typedef struct packed {
		logic req_m, req_s, req_p, start, ack_tgl;
		pxr_sample_t hold;
	} pxr_fe_state_t;
	localparam pxr_regs_t REGS_RST = '{conf1: CONF1_RST, mctl: MCTL_RST, thdl: THD_RST,
		thdh: THD_RST, canc: CANC_RST, por: POR_RST};
endpackage

// File: dv/pxr_host_model.sv
// Purpose: serial host on the register bus, open drain data line with pull-up
// Assumes: scl low 250 ns and high 200 ns per bit, pins change just after a falling ref_clk edge
// Notes: each finished word read is shown on rd_word with a one-cycle rd_done
`timescale 1ns/100ps
module pxr_host_model
	import pxr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sda_oe,
	output logic scl,
	output logic sda_in,
	output logic rd_done,
	output logic [15:0] rd_word
);
	logic m_low = 1'b0;
	// Pull-up: released line reads high, never the last value
	assign sda_in = !(m_low || sda_oe);
	initial begin
		scl = 1'b1;
		rd_done = 1'b0;
		rd_word = 16'h0000;
	end
	task automatic hp();
		repeat (8) @(negedge ref_clk);
	endtask
	// Data moves two cycles after scl falls, never beside an scl edge
	task automatic put(input logic b, output logic s);
		scl = 1'b0;
		repeat (2) @(negedge ref_clk);
		m_low = !b;
		hp();
		scl = 1'b1;
		hp();
		s = sda_in;
	endtask
	task automatic go(input logic again);
		if (again) begin
			scl = 1'b0;
			repeat (2) @(negedge ref_clk);
			m_low = 1'b0;
			hp();
			scl = 1'b1;
			hp();
		end
		m_low = 1'b1;
		hp();
	endtask
	task automatic halt();
		scl = 1'b0;
		repeat (2) @(negedge ref_clk);
		m_low = 1'b1;
		hp();
		scl = 1'b1;
		hp();
		m_low = 1'b0;
		hp();
	endtask
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put(d[i], s);
			q[i] = s;
		end
		put(last, s);
	endtask
	// Whole word in one transaction, low byte first
	task automatic wr(input logic [7:0] c, input logic [15:0] v);
		logic [7:0] q;
		go(1'b0);
		xfer({DEV_ADDR, 1'b0}, 1'b1, q);
		xfer(c, 1'b1, q);
		xfer(v[7:0], 1'b1, q);
		xfer(v[15:8], 1'b1, q);
		halt();
	endtask
	// Two bytes read: low with ack, high with nack
	task automatic rd(input logic [7:0] c);
		logic [7:0] lo;
		logic [7:0] hi;
		go(1'b0);
		xfer({DEV_ADDR, 1'b0}, 1'b1, lo);
		xfer(c, 1'b1, lo);
		go(1'b1);
		xfer({DEV_ADDR, 1'b1}, 1'b1, lo);
		xfer(8'hff, 1'b0, lo);
		xfer(8'hff, 1'b1, hi);
		halt();
		rd_word = {hi, lo};
		rd_done = 1'b1;
		@(negedge ref_clk);
		rd_done = 1'b0;
	endtask
endmodule

// File: dv/pxr_readout_test.sv
// Purpose: self-checking bench for the proximity readout block
// Assumes: short period parameter; force mode except one auto-mode run
// Notes: front end answers each start three fe_clk later
`timescale 1ns/100ps
module pxr_readout_test
	import pxr_pkg::*;
;
	logic ref_clk = 1'b0;
	logic fe_clk = 1'b0;
	logic reset_n, scl, sda_in, sda_out, sda_oe, int_n, rd_done;
	logic fe_valid, fe_sun, fe_start, v_sun;
	logic [11:0] fe_raw, v_raw;
	logic [15:0] rd_word, v;
	logic [15:0] exp_q[$];
	int err_total, checked, starts, served, shots, rnd;
	always #12.5 ref_clk = ~ref_clk;
	initial begin
		#3;
		forever #7.5 fe_clk = ~fe_clk;
	end
	// ID values are arbitrary
	pxr_readout #(.PERIOD_CYC(20), .ID_VERSION(4'h3), .ID_LOW(8'h5a)) uut (
		.ref_clk(ref_clk), .reset_n(reset_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
		.sda_oe(sda_oe), .int_n(int_n), .fe_clk(fe_clk), .fe_valid(fe_valid), .fe_sun(fe_sun),
		.fe_raw(fe_raw), .fe_start(fe_start));
	pxr_host_model host (.ref_clk(ref_clk), .sda_oe(sda_oe), .scl(scl), .sda_in(sda_in),
		.rd_done(rd_done), .rd_word(rd_word));
	// ----------------------------------------------------------------
	// Front end: sample held only in the valid cycle
	// ----------------------------------------------------------------
	initial begin
		fe_valid = 1'b0;
		fe_raw = 12'h000;
		fe_sun = 1'b0;
		forever begin
			@(posedge fe_clk);
			if (fe_start === 1'b1) begin
				starts++;
				repeat (3) @(negedge fe_clk);
				fe_valid = 1'b1;
				fe_raw = v_raw;
				fe_sun = v_sun;
				@(negedge fe_clk);
				fe_valid = 1'b0;
				fe_raw = ~v_raw;
				fe_sun = ~v_sun;
				served++;
			end
		end
	end
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Oldest note against each word read back
	always @(posedge ref_clk) begin
		if (rd_done === 1'b1) begin
			check("read word", rd_word, exp_q.pop_front());
		end
	end
	task automatic reg_rd(input logic [7:0] c, input logic [15:0] e);
		exp_q.push_back(e);
		host.rd(c);
	endtask
	// One forced measurement; bounded wait for the sample to land
	task automatic shot(input logic [11:0] r, input logic s);
		int n;
		n = served;
		v_raw = r;
		v_sun = s;
		shots++;
		host.wr(CMD_MCTL, 16'h0060);
		for (int i = 0; i < 2000 && served == n; i++) @(negedge ref_clk);
		if (served == n) begin
			err_total++;
			conclude();
		end
		repeat (6) @(negedge ref_clk);
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		int n;
		reset_n = 1'b0;
		v_raw = 12'h000;
		v_sun = 1'b0;
		rnd = $urandom(53644);
		repeat (12) @(negedge ref_clk);
		reset_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		check("int_n", {15'h0000, int_n}, 16'h0001);
		reg_rd(CMD_CONF1, CONF1_RST);
		reg_rd(CMD_IDENT, {2'h0, ID_ADDR_CODE, 4'h3, 8'h5a});
		for (int c = 5; c <= 7; c++) begin
			v = 16'($urandom);
			host.wr(8'(c), v);
			reg_rd(8'(c), v & THD_MASK);
		end
		host.wr(CMD_POR, 16'hffff);
		reg_rd(CMD_POR, 16'h0001);
		host.wr(CMD_RESULT, 16'h1234);
		reg_rd(CMD_RESULT, 16'h0000);
		reg_rd(8'h20, 16'h0000);
		host.wr(CMD_MCTL, 16'h0040);
		repeat (300) @(negedge ref_clk);
		check("idle starts", 16'(starts), 16'h0000);
		host.wr(CMD_THDH, 16'hf100);
		host.wr(CMD_THDL, 16'h0050);
		host.wr(CMD_CANC, 16'h0010);
		for (int p = 0; p < 4; p++) begin
			host.wr(CMD_CONF1, {8'h00, 2'h0, 2'(p), INTM_THRESH, 2'h1});
			for (int j = 0; j <= p; j++) begin
				shot(12'h200, 1'b0);
				check("int_n", {15'h0000, int_n}, {15'h0000, j != p});
			end
			reg_rd(CMD_RESULT, 16'h01f0);
			reg_rd(CMD_FLAGS, 16'h0200);
			check("int_n", {15'h0000, int_n}, 16'h0001);
			shot(12'h080, 1'b0);
			check("int_n", {15'h0000, int_n}, 16'h0001);
			for (int j = 0; j <= p; j++) shot(12'h020, 1'b0);
			check("int_n", {15'h0000, int_n}, 16'h0000);
			reg_rd(CMD_FLAGS, 16'h0100);
		end
		reg_rd(CMD_MCTL, 16'h0040);
		host.wr(CMD_CONF1, 16'h000d);
		shot(12'h200, 1'b0);
		check("int_n", {15'h0000, int_n}, 16'h0000);
		shot(12'h080, 1'b0);
		check("int_n", {15'h0000, int_n}, 16'h0000);
		shot(12'h020, 1'b0);
		check("int_n", {15'h0000, int_n}, 16'h0001);
		reg_rd(CMD_FLAGS, 16'h0300);
		host.wr(CMD_CONF1, 16'h0005);
		shot(12'h200, 1'b0);
		check("int_n", {15'h0000, int_n}, 16'h0001);
		reg_rd(CMD_FLAGS, 16'h0000);
		host.wr(CMD_CONF1, 16'h0009);
		shot(12'h080, 1'b1);
		check("int_n", {15'h0000, int_n}, 16'h0000);
		reg_rd(CMD_RESULT, SUN_RESULT);
		reg_rd(CMD_FLAGS, 16'h2000);
		check("int_n", {15'h0000, int_n}, 16'h0001);
		check("starts", 16'(starts), 16'(shots));
		// ----------------------------------------------------------------
		// Auto mode, period code 1: one request per 40 cycles
		// ----------------------------------------------------------------
		rnd = $urandom;
		v_raw = 12'(rnd);
		v_sun = 1'b0;
		v = v_raw > 12'h010 ? {4'h0, v_raw - 12'h010} : 16'h0000;
		host.wr(CMD_MCTL, 16'h0000);
		host.wr(CMD_CONF1, 16'h0040);
		n = starts;
		for (int i = 0; i < 200 && starts == n; i++) @(negedge ref_clk);
		if (starts == n) begin
			err_total++;
			conclude();
		end
		// Window ends midway between two requests, so the count is exact
		n = starts;
		repeat (780) @(negedge ref_clk);
		check("auto starts", 16'(starts - n), 16'h0013);
		host.wr(CMD_CONF1, 16'h0041);
		repeat (100) @(negedge ref_clk);
		n = starts;
		repeat (200) @(negedge ref_clk);
		check("shutdown starts", 16'(starts - n), 16'h0000);
		reg_rd(CMD_RESULT, v);
		// ----------------------------------------------------------------
		// Reset in mid-run brings every register back
		// ----------------------------------------------------------------
		reset_n = 1'b0;
		repeat (12) @(negedge ref_clk);
		reset_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		check("int_n", {15'h0000, int_n}, 16'h0001);
		reg_rd(CMD_THDH, THD_RST);
		reg_rd(CMD_MCTL, MCTL_RST);
		reg_rd(CMD_RESULT, 16'h0000);
		check("sda_out", {15'h0000, sda_out}, 16'h0000);
		repeat (4) @(negedge ref_clk);
		check("pending", 16'(exp_q.size()), 16'h0000);
		conclude();
	end
endmodule
